// File: ccts_pkg.sv
// package: register map, field layout, encodings and timing of the charger control block
// assumes a 200 MHz clock and an analog front end that classifies each sense pin
package ccts_pkg;
  // ==========================================
  // clock and timing
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  // ==========================================
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h0C;
  localparam logic [7:0] ADDR_CTRL    = 8'h10;
  localparam logic [7:0] ADDR_ILIM    = 8'h14;
  localparam logic [7:0] ADDR_FCC     = 8'h18;
  localparam logic [7:0] ADDR_TOPOFF  = 8'h1C;
  localparam logic [7:0] ADDR_VTERM   = 8'h20;
  localparam logic [7:0] ADDR_TIMER   = 8'h24;

  // ==========================================
  // fields and reset values
  localparam int IRQ_W          = 4;
  localparam int IRQ_SUSPEND    = 0;
  localparam int IRQ_RESUME     = 1;
  localparam int IRQ_CFG_FAULT  = 2;
  localparam int IRQ_NO_BATT    = 3;
  localparam int CTRL_PROFILE   = 0;
  localparam logic       CTRL_PROFILE_RST = 1'b1;
  localparam logic [3:0] IRQ_EN_RST       = 4'h0;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;

  // built-in defaults when all sense pins sit on the logic rail
  localparam logic [6:0] ILIM_DEFAULT   = 7'h14;
  localparam logic [8:0] FCC_DEFAULT    = 9'h02D;
  localparam logic [2:0] TOPOFF_DEFAULT = 3'h0;
  localparam logic [7:0] VTERM_DEFAULT  = 8'h00;

  // number of valid resistor steps per sense pin
  localparam logic [3:0] INPUT_LIMIT_SELECT_PIN_STEPS  = 4'hA;
  localparam logic [3:0] TOPOFF_STEPS = 4'h8;
  localparam logic [3:0] FAST_CHARGE_SELECT_PIN_STEPS   = 4'hA;
  localparam logic [3:0] TERMINATION_VOLTAGE_SELECT_PIN_STEPS   = 4'hF;

  // ==========================================
  // types
  typedef enum logic [1:0] {
    PIN_RES  = 2'b00,
    PIN_RAIL = 2'b01,
    PIN_OPEN = 2'b10
  } ccts_pin_kind_t;

  typedef struct packed {
    ccts_pin_kind_t kind;
    logic [3:0]     idx;
  } ccts_pin_t;

  typedef enum logic [2:0] {
    ZONE_GND    = 3'b000,
    ZONE_COLD   = 3'b001,
    ZONE_COOL   = 3'b010,
    ZONE_NORMAL = 3'b011,
    ZONE_WARM   = 3'b100,
    ZONE_HOT    = 3'b101,
    ZONE_RAIL   = 3'b110
  } ccts_zone_t;

  typedef enum logic [1:0] {
    CFG_RES     = 2'b00,
    CFG_DEFAULT = 2'b01,
    CFG_FAULT   = 2'b10
  } ccts_cfg_t;

  typedef enum logic [3:0] {
    DTL_CHARGING = 4'h0,
    DTL_THERMAL  = 4'h1,
    DTL_NO_BATT  = 4'h2,
    DTL_NO_INPUT = 4'h3,
    DTL_CFG      = 4'h4
  } ccts_detail_t;
endpackage

// File: ccts_top.sv
// charger control: sense-pin configuration loader, thermistor suspend logic, axi4-lite registers
// assumes pin classes and thermistor zone come from an analog front end, synchronous to the clock
// How it works
// - stop charging while the thermistor zone is cold or hot
// - clear the charge timer when a thermal suspension begins
// - report suspension in detail code and ok flag, and raise the interrupt
// - back in range, resume charging and restart the charge timer
// - temperature-profile current reduction only while the profile enable bit is one
// - thermistor on the analog supply rail means no battery, so no charging
// - grounded thermistor: no monitoring or profile, battery assumed, auto charge
// - all four pins valid resistors: defaults come from decoded resistor values
// - all four pins on logic rail: built-in defaults, normal charging
// - any mixed pin set keeps system rail regulation but disables charging
// - abnormal pin set drives the status pin to show no charging
// - with input present, cap input current at the programmed limit
// - decode input limit pin: rail 500 mA, resistors 50 to 3000 mA
// - software may overwrite the input current limit field after power-up
// - fast charge current from its pin, nine bits, software may rewrite
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module ccts_top #(
  parameter int TICK_DIV = ccts_pkg::TICK_CYCLES,
  parameter int TIMER_W  = 16
) (
  // clock and reset
  input  wire logic                     I_REF_CLK,
  input  wire logic                     I_RSTN,
  // analog front end
  input  wire ccts_pkg::ccts_pin_t      I_INPUT_LIMIT_SELECT_PIN,
  input  wire ccts_pkg::ccts_pin_t      I_TOPOFF_SELECT_PIN,
  input  wire ccts_pkg::ccts_pin_t      I_FAST_CHARGE_SELECT_PIN,
  input  wire ccts_pkg::ccts_pin_t      I_TERMINATION_VOLTAGE_SELECT_PIN,
  input  wire ccts_pkg::ccts_zone_t     I_THERMISTOR_INPUT,
  input  wire logic                     I_CHARGER_INPUT_VALID,
  // power stage control
  output logic                          O_SYSTEM_RAIL_REG_EN,
  output logic                          O_CHARGE_EN,
  output logic [6:0]                    O_INPUT_CURRENT_LIMIT,
  output logic [8:0]                    O_FAST_CHARGE_CURRENT,
  output logic                          O_PROFILE_ACTIVE,
  output logic                          O_CHARGE_STATUS_PIN,
  output logic [3:0]                    O_CHARGE_DETAIL_CODE,
  output logic                          O_CHARGE_OK_FLAG,
  output logic                          O_IRQ,
  // axi4-lite slave
  input  wire logic [7:0]               I_AWADDR,
  input  wire logic                     I_AWVALID,
  output logic                          O_AWREADY,
  input  wire logic [31:0]              I_WDATA,
  input  wire logic [3:0]               I_WSTRB,
  input  wire logic                     I_WVALID,
  output logic                          O_WREADY,
  output logic [1:0]                    O_BRESP,
  output logic                          O_BVALID,
  input  wire logic                     I_BREADY,
  input  wire logic [7:0]               I_ARADDR,
  input  wire logic                     I_ARVALID,
  output logic                          O_ARREADY,
  output logic [31:0]                   O_RDATA,
  output logic [1:0]                    O_RRESP,
  output logic                          O_RVALID,
  input  wire logic                     I_RREADY
);
  import ccts_pkg::*;

  initial begin
    if (TICK_DIV < 1 || TIMER_W < 1 || TIMER_W > 32) begin
      $error("ccts_top: unsupported TICK_DIV or TIMER_W");
    end
  end

  typedef enum logic [2:0] {
    ST_NO_INPUT = 3'b000,
    ST_CHARGE   = 3'b001,
    ST_SUSPEND  = 3'b010,
    ST_NO_BATT  = 3'b011,
    ST_CFG      = 3'b100
  } ccts_state_t;

  // ==========================================
  // decode helpers
  function automatic logic pin_valid(input ccts_pin_t p, input logic [3:0] steps);
    pin_valid = (p.kind == PIN_RES) && (p.idx < steps);
  endfunction

  // mA in 25 mA units
  function automatic logic [6:0] ilim_code(input logic [3:0] idx);
    case (idx)
      4'h0:    ilim_code = 7'h02;
      4'h1:    ilim_code = 7'h04;
      4'h2:    ilim_code = 7'h08;
      4'h3:    ilim_code = 7'h14;
      4'h4:    ilim_code = 7'h28;
      4'h5:    ilim_code = 7'h3C;
      4'h6:    ilim_code = 7'h50;
      4'h7:    ilim_code = 7'h64;
      default: ilim_code = 7'h78;
    endcase
  endfunction

  // mA in 10 mA units; same resistor steps as the input limit
  function automatic logic [8:0] fcc_code(input logic [3:0] idx);
    fcc_code = 9'({ilim_code(idx), 1'b0}) + 9'({2'b00, ilim_code(idx)} >> 1);
  endfunction

  function automatic logic in_range(input ccts_zone_t z);
    in_range = (z == ZONE_COOL) || (z == ZONE_NORMAL) || (z == ZONE_WARM);
  endfunction

  // ==========================================
  // power-up configuration check
  logic      load_pending;
  logic      load_pulse;
  ccts_cfg_t cfg;
  ccts_cfg_t next_cfg;
  logic      all_res;
  logic      all_rail;

  always_comb begin
    all_res  = pin_valid(I_INPUT_LIMIT_SELECT_PIN, INPUT_LIMIT_SELECT_PIN_STEPS)
             && pin_valid(I_TOPOFF_SELECT_PIN, TOPOFF_STEPS)
             && pin_valid(I_FAST_CHARGE_SELECT_PIN, FAST_CHARGE_SELECT_PIN_STEPS)
             && pin_valid(I_TERMINATION_VOLTAGE_SELECT_PIN, TERMINATION_VOLTAGE_SELECT_PIN_STEPS);
    all_rail = (I_INPUT_LIMIT_SELECT_PIN.kind == PIN_RAIL)
             && (I_TOPOFF_SELECT_PIN.kind == PIN_RAIL)
             && (I_FAST_CHARGE_SELECT_PIN.kind == PIN_RAIL)
             && (I_TERMINATION_VOLTAGE_SELECT_PIN.kind == PIN_RAIL);
    if (all_res) begin
      next_cfg = CFG_RES;
    end else if (all_rail) begin
      next_cfg = CFG_DEFAULT;
    end else begin
      next_cfg = CFG_FAULT;
    end
  end

  // pins are read in the first cycle after reset release, not under reset
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= 1'b0;
    end
  end
  assign load_pulse = load_pending && I_RSTN;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      cfg <= CFG_FAULT;
    end else if (load_pulse) begin
      cfg <= next_cfg;
    end
  end

  // ==========================================
  // bus write decode
  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic        wr_hit;

  assign O_AWREADY = I_AWVALID && I_WVALID && !O_BVALID;
  assign O_WREADY  = O_AWREADY;
  assign wr_fire   = O_AWREADY;
  assign wa        = I_AWADDR;
  assign wd        = I_WDATA;
  assign O_ARREADY = !O_RVALID;
  assign rd_fire   = I_ARVALID && !O_RVALID;

  always_comb begin
    case (wa)
      ADDR_IRQ_CLR, ADDR_IRQ_EN, ADDR_CTRL, ADDR_ILIM,
      ADDR_FCC, ADDR_TOPOFF, ADDR_VTERM: wr_hit = 1'b1;
      default:                           wr_hit = 1'b0;
    endcase
  end

  // ==========================================
  // setting fields: pin defaults at load, software afterwards
  logic [6:0] ilim;
  logic [8:0] fcc;
  logic [2:0] topoff;
  logic [7:0] vterm;
  logic       profile_en;
  logic [3:0] irq_en;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      ilim   <= ILIM_DEFAULT;
      fcc    <= FCC_DEFAULT;
      topoff <= TOPOFF_DEFAULT;
      vterm  <= VTERM_DEFAULT;
    end else if (load_pulse) begin
      if (next_cfg == CFG_RES) begin
        ilim   <= ilim_code(I_INPUT_LIMIT_SELECT_PIN.idx);
        fcc    <= fcc_code(I_FAST_CHARGE_SELECT_PIN.idx);
        topoff <= I_TOPOFF_SELECT_PIN.idx[2:0];
        vterm  <= 8'(I_TERMINATION_VOLTAGE_SELECT_PIN.idx) + 8'h01;
      end
    end else if (wr_fire) begin
      if (wa == ADDR_ILIM && I_WSTRB[0]) begin
        ilim <= wd[6:0];
      end
      if (wa == ADDR_FCC && I_WSTRB[0]) begin
        fcc[7:0] <= wd[7:0];
      end
      if (wa == ADDR_FCC && I_WSTRB[1]) begin
        fcc[8] <= wd[8];
      end
      if (wa == ADDR_TOPOFF && I_WSTRB[0]) begin
        topoff <= wd[2:0];
      end
      if (wa == ADDR_VTERM && I_WSTRB[0]) begin
        vterm <= wd[7:0];
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      profile_en <= CTRL_PROFILE_RST;
      irq_en     <= IRQ_EN_RST;
    end else if (wr_fire && I_WSTRB[0]) begin
      if (wa == ADDR_CTRL) begin
        profile_en <= wd[CTRL_PROFILE];
      end
      if (wa == ADDR_IRQ_EN) begin
        irq_en <= wd[IRQ_W-1:0];
      end
    end
  end

  // ==========================================
  // charge state machine
  ccts_state_t state;
  ccts_state_t next_state;
  logic        batt_present;
  logic        monitor_on;

  assign batt_present = (I_THERMISTOR_INPUT != ZONE_RAIL);
  assign monitor_on   = (I_THERMISTOR_INPUT != ZONE_GND);

  always_comb begin
    if (!I_CHARGER_INPUT_VALID) begin
      next_state = ST_NO_INPUT;
    end else if (cfg == CFG_FAULT) begin
      next_state = ST_CFG;
    end else if (!batt_present) begin
      next_state = ST_NO_BATT;
    end else if (monitor_on && !in_range(I_THERMISTOR_INPUT)) begin
      next_state = ST_SUSPEND;
    end else begin
      next_state = ST_CHARGE;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      state <= ST_NO_INPUT;
    end else if (!load_pulse) begin
      state <= next_state;
    end
  end

  // ==========================================
  // charge timer on a slow tick
  localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  logic [DIV_W-1:0]   div_cnt;
  logic               tick;
  logic [TIMER_W-1:0] timer;
  logic               enter_susp;
  logic               leave_susp;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      div_cnt <= '0;
    end else if (div_cnt == DIV_W'(TICK_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign tick = (div_cnt == DIV_W'(TICK_DIV - 1));

  assign enter_susp = (next_state == ST_SUSPEND) && (state != ST_SUSPEND) && !load_pulse;
  assign leave_susp = (state == ST_SUSPEND) && (next_state == ST_CHARGE) && !load_pulse;

  // saturates rather than wraps so a stuck charge never looks freshly started
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      timer <= '0;
    end else if (enter_susp || leave_susp) begin
      timer <= '0;
    end else if (state == ST_CHARGE && tick && timer != '1) begin
      timer <= timer + 1'b1;
    end
  end

  // ==========================================
  // interrupt status, set wins over clear
  logic [3:0] irq_st;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_SUSPEND]   = enter_susp;
    irq_set[IRQ_RESUME]    = leave_susp;
    irq_set[IRQ_CFG_FAULT] = load_pulse && (next_cfg == CFG_FAULT);
    irq_set[IRQ_NO_BATT]   = (next_state == ST_NO_BATT) && (state != ST_NO_BATT) && !load_pulse;
    irq_clr = (wr_fire && wa == ADDR_IRQ_CLR && I_WSTRB[0]) ? wd[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      irq_st <= '0;
    end else begin
      irq_st <= (irq_st & ~irq_clr) | irq_set;
    end
  end

  // ==========================================
  // power stage outputs, registered
  logic cool_warm;
  assign cool_warm = (I_THERMISTOR_INPUT == ZONE_COOL) || (I_THERMISTOR_INPUT == ZONE_WARM);

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_SYSTEM_RAIL_REG_EN  <= 1'b0;
      O_CHARGE_EN           <= 1'b0;
      O_INPUT_CURRENT_LIMIT <= '0;
      O_FAST_CHARGE_CURRENT <= '0;
      O_PROFILE_ACTIVE      <= 1'b0;
      O_CHARGE_STATUS_PIN   <= 1'b0;
      O_CHARGE_DETAIL_CODE  <= DTL_NO_INPUT;
      O_CHARGE_OK_FLAG      <= 1'b0;
      O_IRQ                 <= 1'b0;
    end else begin
      O_SYSTEM_RAIL_REG_EN  <= I_CHARGER_INPUT_VALID;
      O_CHARGE_EN           <= (state == ST_CHARGE);
      O_INPUT_CURRENT_LIMIT <= I_CHARGER_INPUT_VALID ? ilim : 7'h00;
      // profile halves charge current in the cool and warm zones
      O_PROFILE_ACTIVE      <= profile_en && monitor_on && (state == ST_CHARGE);
      O_FAST_CHARGE_CURRENT <= (profile_en && monitor_on && cool_warm) ? (fcc >> 1) : fcc;
      O_CHARGE_STATUS_PIN   <= (state == ST_CHARGE);
      O_CHARGE_OK_FLAG      <= (state == ST_CHARGE);
      O_IRQ                 <= |(irq_st & irq_en);
      case (state)
        ST_CHARGE:  O_CHARGE_DETAIL_CODE <= DTL_CHARGING;
        ST_SUSPEND: O_CHARGE_DETAIL_CODE <= DTL_THERMAL;
        ST_NO_BATT: O_CHARGE_DETAIL_CODE <= DTL_NO_BATT;
        ST_CFG:     O_CHARGE_DETAIL_CODE <= DTL_CFG;
        default:    O_CHARGE_DETAIL_CODE <= DTL_NO_INPUT;
      endcase
    end
  end

  // ==========================================
  // bus responses
  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (I_ARADDR)
      ADDR_STATUS:  rd_mux = {22'h000000, cfg, I_THERMISTOR_INPUT,
                              O_CHARGE_OK_FLAG, O_CHARGE_DETAIL_CODE};
      ADDR_IRQ_ST:  rd_mux = {28'h0000000, irq_st};
      ADDR_IRQ_CLR: rd_mux = '0;
      ADDR_IRQ_EN:  rd_mux = {28'h0000000, irq_en};
      ADDR_CTRL:    rd_mux = {31'h00000000, profile_en};
      ADDR_ILIM:    rd_mux = {25'h0000000, ilim};
      ADDR_FCC:     rd_mux = {23'h000000, fcc};
      ADDR_TOPOFF:  rd_mux = {29'h00000000, topoff};
      ADDR_VTERM:   rd_mux = {24'h000000, vterm};
      ADDR_TIMER:   rd_mux = 32'(timer);
      default:      rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_BVALID <= 1'b0;
      O_BRESP  <= RESP_OKAY;
    end else if (wr_fire) begin
      O_BVALID <= 1'b1;
      O_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      O_RVALID <= 1'b0;
      O_RDATA  <= '0;
      O_RRESP  <= RESP_OKAY;
    end else if (rd_fire) begin
      O_RVALID <= 1'b1;
      O_RDATA  <= rd_mux;
      O_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end
endmodule

// File: ccts_far_side.sv
// far side model: the four configuration resistors and the thermistor
// assumes the bench picks the wiring once per reset and the zone at any time
`timescale 1ns/1ps
module ccts_far_side (
  // wiring choice
  input  wire logic [1:0]          i_mode,
  input  wire logic [3:0]          i_idx,
  input  wire ccts_pkg::ccts_zone_t i_zone,
  // sense pins
  output ccts_pkg::ccts_pin_t      o_pins [4],
  output ccts_pkg::ccts_zone_t     o_zone
);
  import ccts_pkg::*;
  // ==========================================
  // wiring: 0 resistors, 1 logic rail, 2 mixed, 3 all open
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_pins[k].idx = i_idx;
      o_pins[k].kind = (i_mode == 2'h0 || (i_mode == 2'h2 && k == 0)) ? PIN_RES :
                       (i_mode == 2'h3) ? PIN_OPEN : PIN_RAIL;
    end
  end
  assign o_zone = i_zone;
endmodule

// File: ccts_top_sva.sv
// checker: thermal suspend and power path relations at the top ports
// assumes one clock and the synchronous active-low reset of the top
`timescale 1ns/1ps
module ccts_top_sva (
  // clock and reset
  input wire logic                 I_REF_CLK,
  input wire logic                 I_RSTN,
  // watched ports
  input wire ccts_pkg::ccts_zone_t I_THERMISTOR_INPUT,
  input wire logic                 I_CHARGER_INPUT_VALID,
  input wire logic                 O_SYSTEM_RAIL_REG_EN,
  input wire logic                 O_CHARGE_EN,
  input wire logic [6:0]           O_INPUT_CURRENT_LIMIT,
  input wire logic                 O_PROFILE_ACTIVE,
  input wire logic                 O_CHARGE_STATUS_PIN,
  input wire logic [3:0]           O_CHARGE_DETAIL_CODE,
  input wire logic                 O_CHARGE_OK_FLAG
);
  import ccts_pkg::*;
  // ==========================================
  // relations; three samples cover the two-edge output latency
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  logic out_zone;
  assign out_zone = I_THERMISTOR_INPUT == ZONE_COLD || I_THERMISTOR_INPUT == ZONE_HOT;
  sequence s_held_out;
    (out_zone && I_CHARGER_INPUT_VALID) [*3];
  endsequence
  sequence s_held_normal;
    (I_THERMISTOR_INPUT == ZONE_NORMAL && I_CHARGER_INPUT_VALID) [*3];
  endsequence
  a_out_halts: assert property (out_zone [*3] |-> !O_CHARGE_EN)
    else $error("charging while thermistor out of range");
  a_suspend_report: assert property (O_CHARGE_EN ##0 s_held_out |->
    O_CHARGE_DETAIL_CODE == 4'h1 && !O_CHARGE_OK_FLAG)
    else $error("suspension not reported");
  a_resume_charge: assert property ((O_CHARGE_DETAIL_CODE == 4'h1) ##0 s_held_normal
    |-> O_CHARGE_EN)
    else $error("charging not resumed");
  a_rail_no_batt: assert property ((I_THERMISTOR_INPUT == ZONE_RAIL) [*3] |-> !O_CHARGE_EN)
    else $error("charging with battery removed");
  a_ground_no_prof: assert property ((I_THERMISTOR_INPUT == ZONE_GND) [*3]
    |-> !O_PROFILE_ACTIVE)
    else $error("profile active with grounded thermistor");
  a_ok_status: assert property (O_CHARGE_OK_FLAG |-> O_CHARGE_EN && O_CHARGE_STATUS_PIN &&
    O_CHARGE_DETAIL_CODE == 4'h0)
    else $error("ok flag disagrees with status");
  a_sys_follows: assert property ($past(I_RSTN) |->
    O_SYSTEM_RAIL_REG_EN == $past(I_CHARGER_INPUT_VALID))
    else $error("system rail regulation not following input");
  a_ilim_idle: assert property ((!I_CHARGER_INPUT_VALID) [*2] |->
    O_INPUT_CURRENT_LIMIT == 7'h00)
    else $error("input limit without input");
endmodule
bind ccts_top ccts_top_sva u_sva (
  .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_THERMISTOR_INPUT(I_THERMISTOR_INPUT),
  .I_CHARGER_INPUT_VALID(I_CHARGER_INPUT_VALID), .O_SYSTEM_RAIL_REG_EN(O_SYSTEM_RAIL_REG_EN),
  .O_CHARGE_EN(O_CHARGE_EN), .O_INPUT_CURRENT_LIMIT(O_INPUT_CURRENT_LIMIT),
  .O_PROFILE_ACTIVE(O_PROFILE_ACTIVE), .O_CHARGE_STATUS_PIN(O_CHARGE_STATUS_PIN),
  .O_CHARGE_DETAIL_CODE(O_CHARGE_DETAIL_CODE), .O_CHARGE_OK_FLAG(O_CHARGE_OK_FLAG));

// File: charger_config_thermal_suspend_bench.sv
// bench: pin decode, configuration check, thermal suspend, registers over axi4-lite
// assumes the far side model drives pins and zone; tick divider shortened to 4
`timescale 1ns/1ps
module charger_config_thermal_suspend_bench;
  import ccts_pkg::*;
  // ==========================================
  // signals and model state
  logic        clk = 1'b0, rstn = 1'b0, valid = 1'b1;
  logic [1:0]  mode = 2'h1;
  logic [3:0]  idx = 4'h0, wstrb = 4'hF, dtl;
  ccts_zone_t  zone = ZONE_NORMAL, thermistor_input;
  ccts_pin_t   pins [4];
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, seed = 8'h56;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awready, wready, bvalid, arready, rvalid, chg, prof, stat, ok, irq, system_rail;
  logic [1:0]  bresp, rresp, rsp;
  logic [6:0]  ilim_o;
  logic [8:0]  fcc_o;
  int          fail_count = 0, checks_done = 0, m_ilim, m_fcc, m_cfg_ok, m_prof;
  int          ilim_tab [9] = '{2, 4, 8, 20, 40, 60, 80, 100, 120};
  always #2.5 clk = ~clk;
  ccts_far_side u_far (.i_mode(mode), .i_idx(idx), .i_zone(zone), .o_pins(pins), .o_zone(thermistor_input));
  ccts_top #(.TICK_DIV(4)) DUT (
    .I_REF_CLK(clk), .I_RSTN(rstn), .I_INPUT_LIMIT_SELECT_PIN(pins[0]),
    .I_TOPOFF_SELECT_PIN(pins[1]), .I_FAST_CHARGE_SELECT_PIN(pins[2]),
    .I_TERMINATION_VOLTAGE_SELECT_PIN(pins[3]), .I_THERMISTOR_INPUT(thermistor_input),
    .I_CHARGER_INPUT_VALID(valid), .O_SYSTEM_RAIL_REG_EN(system_rail), .O_CHARGE_EN(chg),
    .O_INPUT_CURRENT_LIMIT(ilim_o), .O_FAST_CHARGE_CURRENT(fcc_o), .O_PROFILE_ACTIVE(prof),
    .O_CHARGE_STATUS_PIN(stat), .O_CHARGE_DETAIL_CODE(dtl), .O_CHARGE_OK_FLAG(ok), .O_IRQ(irq),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready));
  // ==========================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    tb = 1'b0;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta = ta || awready;
      tw = tw || wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (!tb) begin
      @(negedge clk);
      tb = bvalid;
      rsp = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask
  // pins are sampled once, so every wiring needs its own reset
  task automatic boot(input logic [1:0] m, input logic [3:0] i, input int n);
    @(posedge clk);
    rstn <= 1'b0;
    mode <= m;
    idx <= i;
    repeat (n) @(posedge clk);
    rstn <= 1'b1;
    m_cfg_ok = (m == 2'h0 && i < 4'h8) || m == 2'h1;
    // a faulty wiring loads nothing, so the fields keep their built-in defaults
    m_ilim = (m == 2'h0 && m_cfg_ok) ? ilim_tab[i] : 20;
    m_fcc = (m == 2'h0 && m_cfg_ok) ? ilim_tab[i] * 5 / 2 : 45;
    m_prof = 1;
    repeat (3) @(posedge clk);
  endtask
  task automatic step(input logic v, input ccts_zone_t z);
    int d;
    @(posedge clk);
    valid <= v;
    zone <= z;
    repeat (3) @(posedge clk);
    @(negedge clk);
    d = !v ? 3 : !m_cfg_ok ? 4 : z == ZONE_RAIL ? 2 : (z == ZONE_COLD || z == ZONE_HOT) ? 1 : 0;
    check(dtl, d);
    check(chg, d == 0);
    check(ok, d == 0);
    check(stat, d == 0);
    check(system_rail, v);
    check(ilim_o, v ? m_ilim : 0);
    check(prof, m_prof && z != ZONE_GND && d == 0);
    check(fcc_o, (m_prof && (z == ZONE_COOL || z == ZONE_WARM)) ? m_fcc / 2 : m_fcc);
  endtask
  // ==========================================
  // scenarios
  initial begin
    boot(2'h1, 4'h0, 20);
    rd_reg(ADDR_CTRL);
    check(rd, 32'h1);
    rd_reg(ADDR_IRQ_EN);
    check(rd, 32'h0);
    step(1'b1, ZONE_NORMAL);
    for (int i = 0; i < 9; i++) begin
      boot(2'h0, i[3:0], 2);
      step(1'b1, ZONE_NORMAL);
      rd_reg(ADDR_ILIM);
      check(rd, m_ilim);
      rd_reg(ADDR_TOPOFF);
      check(rd, m_cfg_ok ? i : 0);
    end
    for (int m = 2; m < 4; m++) begin
      boot(m[1:0], 4'h3, 2);
      step(1'b1, ZONE_NORMAL);
    end
    boot(2'h0, 4'h5, 2);
    mode <= 2'h1;
    step(1'b1, ZONE_NORMAL);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      m_ilim = seed[6:0];
      wr(ADDR_ILIM, {25'h0, seed[6:0]}, 4'hF);
      check(rsp, RESP_OKAY);
      step(1'b1, ZONE_NORMAL);
    end
    seed = lfsr(seed);
    m_fcc = {seed[0], seed};
    wr(ADDR_FCC, {23'h0, seed[0], seed}, 4'h3);
    step(1'b1, ZONE_COOL);
    m_prof = 0;
    wr(ADDR_CTRL, 32'h0, 4'hF);
    step(1'b1, ZONE_WARM);
    wr(ADDR_IRQ_EN, 32'hF, 4'hF);
    for (int k = 0; k < 2; k++) begin
      repeat (40) @(posedge clk);
      step(1'b1, k ? ZONE_HOT : ZONE_COLD);
      check(irq, 1'b1);
      rd_reg(ADDR_TIMER);
      check(rd, 32'h0);
      rd_reg(ADDR_IRQ_ST);
      check(rd[0], 1'b1);
      wr(ADDR_IRQ_CLR, 32'hF, 4'hF);
      step(1'b1, ZONE_NORMAL);
      rd_reg(ADDR_TIMER);
      check(rd < 8, 1'b1);
    end
    wr(ADDR_IRQ_EN, 32'h0, 4'hF);
    wr(ADDR_IRQ_CLR, 32'hF, 4'hF);
    step(1'b1, ZONE_HOT);
    check(irq, 1'b0);
    wr(ADDR_IRQ_EN, 32'h1, 4'hF);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(irq, 1'b1);
    step(1'b1, ZONE_RAIL);
    step(1'b1, ZONE_GND);
    step(1'b0, ZONE_GND);
    rd_reg(8'h3C);
    check(rsp, RESP_SLVERR);
    check(rd, 32'h0);
    wr(ADDR_STATUS, 32'h0, 4'hF);
    check(rsp, RESP_SLVERR);
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict;
  end
endmodule
